// *** hw/hbac_top.v ***
// host bus agent control: strobes, priority request, reset strap, data handshake and inversion
// Overview of operation
// - bus owner strobes first request cycle
// - hub drives request strobe for own cycles
// - block-next-request stops owner's new requests
// - hub gains address bus via priority request
// - bus request 0 low during processor reset
// - strap setup 4, hold 2..20 clocks
// - release bus request 0 after hold
// - processor reset follows platform reset plus 1ms
// - data owner holds bus for multi-cycle transfers
// - defer notice marks deferred or retried snoop
// - at most 8 low bits per group
// - four flags cover four 16-bit groups
// - data-valid asserted in each transfer cycle
// - lock blocks downstream memory accesses
`include "hbac_regs.vh"
`default_nettype none
// block layout, one clock domain throughout
// - every pin input passes a two-flop capture first
// - the platform reset pin is captured like any other pin
// - a small state machine stretches processor reset
// - the strap on bus request 0 is driven low from reset on
// - the strap floats a fixed number of clocks after release
// - the hub asks for the address bus with its priority request
// - the hub strobes only when lock, block and strobe lines are idle
// - one pending hub request at a time, extra pulses merge
// - the defer notice is a single-cycle pulse per request
// - outgoing beats are encoded per 16-bit group
// - a group goes out inverted when more than 8 bits would be low
// - flags are driven low for an inverted group
// - incoming beats are decoded with the same flag sense
// - data valid and bus hold travel with each outgoing beat
// - bus hold stays low on every beat but the last
// - an atomic sequence blocks downstream memory access
// hazards and limits
// - pin capture adds two clocks of latency on every input
// - a block request seen late cannot stop a strobe already decided
// - the hub's own beats loop back through the receive path
// - the received word is only meaningful while rx valid is high
// - the reset stretch counter is 32 bits wide
// - a stretch beyond 2^32 clocks is not supported
// - the strap hold count must stay within 2 to 20 clocks
// - platform reset forces processor reset back within 3 clocks
// - platform reset also re-drives the strap low
// outputs
// - all outputs come straight from flip-flops
// - every output enable is high while the hub drives the pin
// - released data and flag pins keep their last level, released control pins and the strap return high, with enable low
// - no output changes during i_rst_n except to reset values
module hbac_top #(
  parameter integer RST_EXT_CYC = `HBAC_CPU_RST_EXT_CYC,  // processor reset stretch
  parameter integer HOLD_CYC    = `HBAC_STRAP_HOLD_CYC    // strap hold after release
) (
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  input  wire        i_platform_reset_in_n,      // from the io hub, asynchronous
  input  wire        i_own_req,                  // pulse: hub wants to issue a cycle
  input  wire        i_own_defer,                // pulse: defer snooped transaction
  input  wire        i_tx_valid,                 // hub data beat to send
  input  wire        i_tx_last,                  // final beat of this transfer
  input  wire [63:0] i_tx_data,                  // raw hub data
  input  wire        i_request_phase_strobe_n,   // pin input
  input  wire        i_block_next_request_n,     // pin input
  input  wire        i_atomic_lock_n,            // pin input
  input  wire        i_data_bus_hold_n,          // pin input
  input  wire        i_data_valid_n,             // pin input
  input  wire [63:0] i_host_data_bus,            // pin input
  input  wire [3:0]  i_data_inversion_flags,     // pin input
  output reg         o_request_phase_strobe_n,
  output reg         o_request_phase_strobe_oe,
  output reg         o_priority_bus_request_n,
  output reg         o_symmetric_bus_request0_n,
  output reg         o_symmetric_bus_request0_oe,
  output reg         o_processor_reset_n,
  output reg         o_defer_notice_n,
  output reg         o_data_bus_hold_n,
  output reg         o_data_bus_hold_oe,
  output reg         o_data_valid_n,
  output reg         o_data_valid_oe,
  output reg  [63:0] o_host_data_bus,
  output reg         o_host_data_bus_oe,
  output reg  [3:0]  o_data_inversion_flags,
  output reg         o_data_inversion_flags_oe,
  output reg         o_own_req_done,             // pulse: hub request strobed
  output reg         o_tx_ready,                 // hub may present next beat
  output reg         o_downstream_mem_block,     // level: no downstream memory access
  output reg  [63:0] o_rx_data,                  // decoded incoming data
  output reg         o_rx_valid                  // pulse: incoming data beat
);
  // synchronisers, first stage read only by second
  reg        rst_meta_q, rst_sync_q; // platform reset capture
  reg [4:0]  ctl_meta_q, ctl_sync_q; // strobe, bnr, lock, dbsy, drdy
  reg [67:0] dat_meta_q, dat_sync_q; // flags and data
  wire       ads_n  = ctl_sync_q[0];
  wire       bnr_n  = ctl_sync_q[1];
  wire       lock_n = ctl_sync_q[2];
  wire       drdy_n = ctl_sync_q[4];

  // two-flop capture of all pin inputs
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
      ctl_meta_q <= 5'h1F;
      ctl_sync_q <= 5'h1F;
      dat_meta_q <= 68'h0;
      dat_sync_q <= 68'h0;
    end else begin
      rst_meta_q <= i_platform_reset_in_n;
      rst_sync_q <= rst_meta_q;
      ctl_meta_q <= {i_data_valid_n, i_data_bus_hold_n, i_atomic_lock_n,
                     i_block_next_request_n, i_request_phase_strobe_n};
      ctl_sync_q <= ctl_meta_q;
      dat_meta_q <= {i_data_inversion_flags, i_host_data_bus};
      dat_sync_q <= dat_meta_q;
    end
  end

  // processor reset and strap sequencing
  localparam [1:0] ST_RESET = 2'h0;  // platform reset asserted
  localparam [1:0] ST_EXT   = 2'h1;  // stretch count running
  localparam [1:0] ST_HOLD  = 2'h2;  // strap hold after release
  localparam [1:0] ST_RUN   = 2'h3;  // normal operation
  reg [1:0]  st_q;
  reg [31:0] cnt_q;

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q                        <= ST_RESET;
      cnt_q                       <= 32'h0;
      o_processor_reset_n         <= 1'b0;
      o_symmetric_bus_request0_n  <= 1'b0;
      o_symmetric_bus_request0_oe <= 1'b1;
    end else if (!rst_sync_q) begin
      // platform reset forces processor reset, strap driven low
      st_q                        <= ST_RESET;
      cnt_q                       <= 32'h0;
      o_processor_reset_n         <= 1'b0;
      o_symmetric_bus_request0_n  <= 1'b0;
      o_symmetric_bus_request0_oe <= 1'b1;
    end else begin
      case (st_q)
        ST_RESET: begin
          st_q  <= ST_EXT;
          cnt_q <= 32'h0;
        end
        ST_EXT: begin
          // stretch, strap already low far beyond 4 clocks of setup
          if (cnt_q >= RST_EXT_CYC - 1) begin
            st_q                <= ST_HOLD;
            cnt_q               <= 32'h0;
            o_processor_reset_n <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_HOLD: begin
          // keep strap low for hold window then float it
          if (cnt_q >= HOLD_CYC - 1) begin
            st_q                        <= ST_RUN;
            o_symmetric_bus_request0_oe <= 1'b0;
            o_symmetric_bus_request0_n  <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_RUN: begin
          st_q <= ST_RUN;
        end
        default: begin
          st_q <= ST_RESET;
        end
      endcase
    end
  end

  // request phase: priority request then own strobe
  // pend_q: a hub cycle waits for the bus
  // phase2_q: second cycle of the hub's request phase
  // locked_q: atomic sequence in progress
  reg pend_q, phase2_q, locked_q;
  wire run = (st_q == ST_RUN);  // hub may issue cycles and beats

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q                    <= 1'b0;
      phase2_q                  <= 1'b0;
      locked_q                  <= 1'b0;
      o_priority_bus_request_n  <= 1'b1;
      o_request_phase_strobe_n  <= 1'b1;
      o_request_phase_strobe_oe <= 1'b0;
      o_own_req_done            <= 1'b0;
      o_downstream_mem_block    <= 1'b0;
      o_defer_notice_n          <= 1'b1;
    end else begin
      o_own_req_done           <= 1'b0;
      o_request_phase_strobe_n <= 1'b1;
      o_request_phase_strobe_oe <= 1'b0;
      o_defer_notice_n         <= ~(i_own_defer & run);
      // lock seen with a strobe starts an atomic sequence until released
      if (!lock_n && !ads_n)
        locked_q <= 1'b1;
      else if (lock_n)
        locked_q <= 1'b0;
      o_downstream_mem_block <= ~lock_n | locked_q;
      if (i_own_req && run)
        pend_q <= 1'b1;
      // assert priority request while a hub cycle is pending
      o_priority_bus_request_n <= ~(pend_q | (i_own_req & run));
      if (phase2_q) begin
        phase2_q <= 1'b0;                               // second request cycle
      end else if (pend_q && !o_priority_bus_request_n && lock_n && bnr_n && ads_n) begin
        // owner has yielded, lock released, no block: strobe first cycle
        o_request_phase_strobe_n  <= 1'b0;
        o_request_phase_strobe_oe <= 1'b1;
        phase2_q                  <= 1'b1;
        pend_q                    <= 1'b0;
        o_own_req_done            <= 1'b1;
      end
    end
  end

  // inversion per 16-bit group, generate loop
  // each group is decided by its own process, so no vector has two drivers
  wire [63:0] enc_data;  // encoded outgoing data
  wire [3:0]  enc_inv;   // high where a group goes out inverted
  genvar g;
  generate
    for (g = 0; g < `HBAC_GROUPS; g = g + 1) begin : grp
      reg [4:0]  zeros;  // low bits this group would drive
      reg        inv;    // invert decision for this group
      reg [15:0] dat;    // group after optional inversion
      integer    b;      // bit index
      // count low bits, then decide inversion
      always @* begin
        zeros = 5'h0;
        inv   = 1'b0;
        dat   = 16'h0;
        for (b = 0; b < `HBAC_GROUP_W; b = b + 1) begin
          zeros = zeros + {4'h0, ~i_tx_data[g*16+b]};
        end
        // invert when more than 8 bits would be low
        inv = (zeros > `HBAC_GROUP_LOW_MAX);
        dat = inv ? ~i_tx_data[g*16 +: 16] : i_tx_data[g*16 +: 16];
      end
      assign enc_inv[g]           = inv;
      assign enc_data[g*16 +: 16] = dat;
    end
  endgenerate

  // data phase drive and receive
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_host_data_bus           <= 64'h0;
      o_host_data_bus_oe        <= 1'b0;
      o_data_inversion_flags    <= 4'hF;
      o_data_inversion_flags_oe <= 1'b0;
      o_data_valid_n            <= 1'b1;
      o_data_valid_oe           <= 1'b0;
      o_data_bus_hold_n         <= 1'b1;
      o_data_bus_hold_oe        <= 1'b0;
      o_tx_ready                <= 1'b0;
      o_rx_data                 <= 64'h0;
      o_rx_valid                <= 1'b0;
    end else begin
      o_tx_ready <= run;
      if (i_tx_valid && run) begin
        o_host_data_bus           <= enc_data;
        o_data_inversion_flags    <= ~enc_inv;
        o_host_data_bus_oe        <= 1'b1;
        o_data_inversion_flags_oe <= 1'b1;
        o_data_valid_n            <= 1'b0;
        o_data_valid_oe           <= 1'b1;
        o_data_bus_hold_n         <= i_tx_last;
        o_data_bus_hold_oe        <= 1'b1;
      end else begin
        o_host_data_bus_oe        <= 1'b0;
        o_data_inversion_flags_oe <= 1'b0;
        o_data_valid_n            <= 1'b1;
        o_data_valid_oe           <= 1'b0;
        o_data_bus_hold_n         <= 1'b1;
        o_data_bus_hold_oe        <= 1'b0;
      end
      // incoming beat: undo inversion per group
      o_rx_valid <= ~drdy_n;
      o_rx_data  <= dat_sync_q[63:0] ^ {{16{~dat_sync_q[67]}}, {16{~dat_sync_q[66]}},
                                        {16{~dat_sync_q[65]}}, {16{~dat_sync_q[64]}}};
    end
  end
endmodule // hbac_top
`default_nettype wire

// *** include/hbac_regs.vh ***
// timing counts and field positions for the host bus agent control block
`ifndef HBAC_REGS_VH
`define HBAC_REGS_VH
`define HBAC_CLK_PERIOD_NS      20
`define HBAC_CPU_RST_EXT_NS     1000000
`define HBAC_CPU_RST_EXT_CYC    (`HBAC_CPU_RST_EXT_NS / `HBAC_CLK_PERIOD_NS)
`define HBAC_STRAP_SETUP_CYC    4
`define HBAC_STRAP_HOLD_MIN_CYC 2
`define HBAC_STRAP_HOLD_MAX_CYC 20
`define HBAC_STRAP_HOLD_CYC     4
`define HBAC_GROUP_W            16
`define HBAC_GROUP_LOW_MAX      8
`define HBAC_GROUPS             4
`endif

// *** testbench/hbac_cpu_model.sv ***
// processor-side agent model: request strobe and data beats
`default_nettype none
module hbac_cpu_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_go,       // issue one request
  input  wire logic        i_send,     // drive one beat
  input  wire logic [63:0] i_raw,      // raw beat value
  input  wire logic        i_pri_n,    // hub priority request pin
  input  wire logic        i_lock_n,   // lock held by this agent
  output logic             o_stb_n,
  output logic             o_dv_n,
  output logic             o_hold_n,
  output logic [63:0]      o_dat,
  output logic [3:0]       o_flg
);
  timeunit 1ns;
  timeprecision 1ns;
  // inversion per 16-bit group, flag low means inverted
  function automatic logic [67:0] enc(input logic [63:0] r);
    logic [15:0] g;
    enc = 68'h0;
    for (int k = 0; k < 4; k++) begin
      g = r[16*k +: 16];
      enc[64+k] = ($countones(~g) <= 8);                       // flag k covers group k
      enc[16*k +: 16] = enc[64+k] ? g : ~g;                     // at most 8 low bits
    end
  endfunction
  initial {o_stb_n, o_dv_n, o_hold_n, o_flg, o_dat} = {3'h7, 68'h0};
  // all pins change just after the edge
  always @(posedge i_core_clk) begin
    o_stb_n <= !(i_go && (i_pri_n || !i_lock_n));             // yield to priority unless locked
    o_dv_n <= !i_send;                                         // valid on each beat
    o_hold_n <= 1'b1;                                          // single beats need no hold
    {o_flg, o_dat} <= i_send ? enc(i_raw) : ~{o_flg, o_dat};  // released lines flip
  end
endmodule // hbac_cpu_model
`default_nettype wire

// *** testbench/hbac_properties.sv ***
// assertion checker for the host bus agent control block
`default_nettype none
module hbac_props #(
  parameter integer RST_EXT_CYC = 20,  // processor reset stretch
  parameter integer HOLD_CYC    = 4    // strap hold after release
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_platform_reset_in_n,
  input wire logic i_own_defer,
  input wire logic i_tx_valid,
  input wire logic i_tx_last,
  input wire logic i_block_next_request_n,
  input wire logic i_atomic_lock_n,
  input wire logic o_request_phase_strobe_n,
  input wire logic o_request_phase_strobe_oe,
  input wire logic o_priority_bus_request_n,
  input wire logic o_symmetric_bus_request0_n,
  input wire logic o_symmetric_bus_request0_oe,
  input wire logic o_processor_reset_n,
  input wire logic o_defer_notice_n,
  input wire logic o_data_bus_hold_n,
  input wire logic o_data_valid_n,
  input wire logic o_own_req_done,
  input wire logic o_tx_ready,
  input wire logic o_downstream_mem_block
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  strobe_one_cycle_a: assert property (!o_request_phase_strobe_n |-> o_request_phase_strobe_oe && o_own_req_done
    ##1 o_request_phase_strobe_n) else $error("strobe not a driven single cycle");
  strobe_after_pri_a: assert property (!o_request_phase_strobe_n |-> $past(!o_priority_bus_request_n))
    else $error("strobe without priority request");
  block_stops_a: assert property (!i_block_next_request_n [*4] |-> o_request_phase_strobe_n)
    else $error("strobe while blocked");
  strap_low_a: assert property (!o_processor_reset_n [*4] |-> !o_symmetric_bus_request0_n &&
    o_symmetric_bus_request0_oe) else $error("strap not low in reset");
  strap_window_a: assert property ($rose(o_processor_reset_n) |-> (o_symmetric_bus_request0_oe &&
    !o_symmetric_bus_request0_n) [*2] ##[1:18] !o_symmetric_bus_request0_oe) else $error("strap hold wrong");
  cpu_rst_follow_a: assert property ($fell(i_platform_reset_in_n) |-> ##[1:4] !o_processor_reset_n)
    else $error("processor reset not asserted");
  cpu_rst_stretch_a: assert property ($rose(i_platform_reset_in_n) |-> !o_processor_reset_n [*8])
    else $error("processor reset too short");
  defer_pulse_a: assert property (i_own_defer && o_tx_ready |=> !o_defer_notice_n ##1 o_defer_notice_n)
    else $error("defer notice wrong");
  beat_valid_a: assert property (i_tx_valid && o_tx_ready |=> !o_data_valid_n)
    else $error("data valid missing");
  beat_hold_a: assert property (i_tx_valid && o_tx_ready && !i_tx_last |=> !o_data_bus_hold_n)
    else $error("bus hold missing");
  lock_block_a: assert property (!i_atomic_lock_n [*4] |-> o_downstream_mem_block)
    else $error("lock did not block");
  cover property (!o_request_phase_strobe_n);
  cover property ($rose(o_processor_reset_n));
  cover property (i_tx_valid && !i_tx_last && o_tx_ready);
endmodule // hbac_props
bind hbac_top hbac_props #(.RST_EXT_CYC(RST_EXT_CYC), .HOLD_CYC(HOLD_CYC)) u_props (.*);
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the host bus agent control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_platform_reset_in_n = 1'b0, i_own_req = 1'b0, i_own_defer = 1'b0;
  logic i_tx_valid = 1'b0, i_tx_last = 1'b0, i_block_next_request_n = 1'b1, i_atomic_lock_n = 1'b1, snd = 1'b0;
  logic [63:0] i_tx_data = 64'h0, raw = 64'h0;
  logic [31:0] seed = 32'h131E4;
  int n_mismatch = 0, compares = 0, ndone = 0;
  logic [67:0] qtx[$];
  logic [63:0] qrx[$];
  wire logic o_request_phase_strobe_n, o_request_phase_strobe_oe, o_priority_bus_request_n, o_own_req_done, m_stb;
  wire logic o_symmetric_bus_request0_n, o_symmetric_bus_request0_oe, o_processor_reset_n, o_defer_notice_n, m_dv;
  wire logic o_data_bus_hold_n, o_data_bus_hold_oe, o_data_valid_n, o_data_valid_oe, o_host_data_bus_oe, m_hld;
  wire logic o_data_inversion_flags_oe, o_tx_ready, o_downstream_mem_block, o_rx_valid;
  wire logic [63:0] o_host_data_bus, o_rx_data, m_dat;
  wire logic [3:0] o_data_inversion_flags, m_flg;
  // shared pins resolve from both drivers
  wire logic i_request_phase_strobe_n = o_request_phase_strobe_oe ? o_request_phase_strobe_n : m_stb;
  wire logic i_data_valid_n = o_data_valid_oe ? o_data_valid_n : m_dv;
  wire logic i_data_bus_hold_n = o_data_bus_hold_oe ? o_data_bus_hold_n : m_hld;
  wire logic [63:0] i_host_data_bus = o_host_data_bus_oe ? o_host_data_bus : m_dat;
  wire logic [3:0] i_data_inversion_flags = o_data_inversion_flags_oe ? o_data_inversion_flags : m_flg;
  hbac_top #(.RST_EXT_CYC(20), .HOLD_CYC(4)) dut (.*);
  hbac_cpu_model u_cpu (.i_core_clk(i_core_clk), .i_go(1'b0), .i_send(snd), .i_raw(raw),
    .i_pri_n(o_priority_bus_request_n), .i_lock_n(i_atomic_lock_n), .o_stb_n(m_stb), .o_dv_n(m_dv),
    .o_hold_n(m_hld), .o_dat(m_dat), .o_flg(m_flg));
  initial forever #10 i_core_clk = ~i_core_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic nxt(input int i);
    seed = xs(seed);
    raw = (i == 0) ? 64'h0 : (i == 1) ? ~64'h0 : {xs(seed), seed};
  endtask
  task automatic cmp(input logic [67:0] e, input logic [67:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // results come off the queues in order
  always @(negedge i_core_clk) begin
    if (o_data_valid_oe === 1'b1 && o_data_valid_n === 1'b0)
      cmp(qtx.size() ? qtx.pop_front() : 68'hX, {o_data_inversion_flags, o_host_data_bus});
    if (o_rx_valid === 1'b1)
      cmp(qrx.size() ? qrx.pop_front() : 64'hX, o_rx_data);
  end
  always @(negedge i_core_clk) if (o_own_req_done === 1'b1) ndone++;
  initial begin
    tick(20);
    i_rst_n = 1'b1;
    for (int r = 0; r < 2; r++) begin
      tick(4);
      i_platform_reset_in_n = 1'b1;
      tick(6);
      cmp(68'h0, {o_processor_reset_n, o_symmetric_bus_request0_n, !o_symmetric_bus_request0_oe});
      tick(40);
      cmp(68'h6, {o_tx_ready, o_processor_reset_n, o_symmetric_bus_request0_oe});
      i_block_next_request_n = 1'b0;
      tick(3);
      i_own_req = 1'b1;
      tick(1);
      i_own_req = 1'b0;
      tick(8);
      cmp(68'h0 + 2 * r, ndone);
      i_block_next_request_n = 1'b1;
      i_own_defer = 1'b1;
      tick(1);
      i_own_defer = 1'b0;
      tick(8);
      cmp(68'h1 + 2 * r, ndone);
      i_atomic_lock_n = 1'b0;
      tick(3);
      i_own_req = 1'b1;
      tick(1);
      i_own_req = 1'b0;
      tick(6);
      cmp(68'h3 + 4 * r, {ndone[2:0], o_downstream_mem_block});
      i_atomic_lock_n = 1'b1;
      tick(8);
      cmp(68'h4 + 4 * r, {ndone[2:0], o_downstream_mem_block});
      for (int i = 0; i < 10; i++) begin
        nxt(i);
        {i_tx_valid, i_tx_last, i_tx_data} = {1'b1, i % 4 == 3, raw};
        qtx.push_back(u_cpu.enc(raw));
        qrx.push_back(raw);
        tick(1);
      end
      i_tx_valid = 1'b0;
      tick(4);
      for (int i = 0; i < 10; i++) begin
        nxt(i);
        snd = 1'b1;
        qrx.push_back(raw);
        tick(1);
      end
      snd = 1'b0;
      tick(8);
      cmp(68'h0, qtx.size() + qrx.size());
      i_platform_reset_in_n = 1'b0;
    end
    final_report;
  end
  initial begin
    #100us;
    n_mismatch++;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
